// >>> bench/stp_core_tb.sv
// self-checking bench for the stepper control core
`timescale 1ns/1ps
module stp_core_tb;
	import stp_pkg::*;
	logic        mclk, rst, reset_pin, low_power_pin_n, step_pin, dir_pin;
	logic        frame_select, serial_clk, serial_in_pin, serial_out_pin;
	logic [1:0]  ocp_raw, gate_fault_raw, bridge_en;
	logic        overtemp_raw, undervolt_raw, oe_n, gate_reg_en;
	logic        step_advance, step_heading, fault_lvl;
	logic [11:0] rd_junk;
	logic [11:0] cfg [7];
	logic [11:0] rv [7] = '{CTRL_RST, TORQUE_RST, OFF_RST, BLANK_RST, DECAY_RST,
		12'h000, DRIVE_RST};
	logic [11:0] msk [7] = '{CTRL_WMSK, TORQ_WMSK, W9_MSK, W9_MSK, DECAY_MSK,
		12'h000, 12'hfff};
	int          mismatches, total_checks, adv_cnt, cyc;
	stp_core u_stp_core (.mclk(mclk), .rst(rst), .reset_pin(reset_pin),
		.low_power_pin_n(low_power_pin_n), .frame_select(frame_select),
		.serial_clk(serial_clk), .serial_in_pin(serial_in_pin), .step_pin(step_pin),
		.dir_pin(dir_pin), .ocp_raw(ocp_raw), .gate_fault_raw(gate_fault_raw),
		.overtemp_raw(overtemp_raw), .undervolt_raw(undervolt_raw),
		.serial_out_pin(serial_out_pin), .fault_pin_low_o(fault_lvl),
		.fault_pin_low_oe_n(oe_n),
		.bridge_en(bridge_en), .gate_reg_en(gate_reg_en), .step_advance(step_advance),
		.step_heading(step_heading), .control_config(cfg[0]),
		.current_sample_config(cfg[1]), .off_time_config(cfg[2]),
		.blanking_config(cfg[3]), .decay_config(cfg[4]), .drive_config(cfg[6]));
	stp_host u_stp_host (.mclk(mclk), .frame_select(frame_select),
		.serial_clk(serial_clk), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results;
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		logic [11:0] r;
		u_stp_host.xfer({1'b0, a, d}, 16, 0, r);
	endtask
	// read data bits carry junk, which the device must ignore
	task automatic rc(input logic [2:0] a, input logic [11:0] e, input string m);
		logic [11:0] r;
		u_stp_host.xfer({1'b1, a, 12'h5a5}, 16, 0, r);
		chk(r, e, m);
	endtask
	task automatic stp;
		step_pin <= 1'b1;
		wt(6);
		step_pin <= 1'b0;
		wt(6);
	endtask
	task automatic hw(input logic [1:0] b, input logic f, input string m);
		chk(12'(bridge_en), 12'(b), m);
		chk(12'(oe_n), 12'(f), m);
		// open drain: only the enable moves, the level must stay low
		chk(12'(fault_lvl), 12'h000, m);
	endtask
	// ----------------------------------------------------------------
	// clock, step counter, timeout
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (step_advance === 1'b1)
			adv_cnt++;
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end
	initial
	begin
		{mismatches, total_checks, adv_cnt, cyc} = '0;
		{reset_pin, step_pin, dir_pin, overtemp_raw, undervolt_raw} = '0;
		{ocp_raw, gate_fault_raw} = '0;
		low_power_pin_n = 1'b1;
		rst = 1'b1;
		wt(4);
		rst <= 1'b0;
		wt(6);
		rc(3'h7, 12'h000, "status rst");
		for (int a = 0; a < 7; a++)
		begin
			if (a != 5)
				chk(cfg[a], rv[a], "default");
			wr(3'(a), 12'hd6f);
			if (a != 5)
				chk(cfg[a], 12'hd6f & msk[a], "write");
			rc(3'(a), 12'hd6f & msk[a] & (a == 1 ? TORQ_RMSK : 12'hfff), "rdbk");
		end
		chk(12'(adv_cnt), 12'h001, "single adv");
		dir_pin <= 1'b1;
		wt(6);
		chk(12'(step_heading), 12'h000, "heading");
		stp();
		chk(12'(adv_cnt), 12'h002, "step pin");
		u_stp_host.xfer({1'b0, A_OFF, 12'h0a5}, 8, 0, rd_junk);
		chk(cfg[2], 12'h16f, "short frame");
		u_stp_host.xfer({1'b0, A_OFF, 12'h0a5}, 16, 20, rd_junk);
		chk(cfg[2], 12'h0a5, "split frame");
		wr(A_DRIVE, 12'ha51);
		hw(2'b11, 1'b1, "run");
		ocp_raw <= 2'b01;
		wt(40);
		ocp_raw <= 2'b00;
		wt(6);
		hw(2'b11, 1'b1, "ocp short");
		ocp_raw <= 2'b01;
		wt(70);
		ocp_raw <= 2'b00;
		wt(4);
		hw(2'b00, 1'b0, "ocp idx");
		stp();
		chk(12'(adv_cnt), 12'h002, "step blocked");
		rc(3'h7, 12'h002, "ocp a flag");
		hw(2'b00, 1'b0, "ocp held");
		wr(3'h7, 12'h000);
		hw(2'b11, 1'b1, "ocp clr");
		wr(A_OFF, 12'h100);
		ocp_raw <= 2'b10;
		wt(70);
		ocp_raw <= 2'b00;
		wt(4);
		hw(2'b01, 1'b0, "ocp bypass");
		rc(3'h7, 12'h004, "ocp b flag");
		wr(3'h7, 12'h000);
		gate_fault_raw <= 2'b01;
		wt(6);
		gate_fault_raw <= 2'b00;
		wt(4);
		hw(2'b10, 1'b0, "gate");
		rc(3'h7, 12'h008, "gate flag");
		hw(2'b10, 1'b0, "gate held");
		wr(3'h7, 12'h000);
		hw(2'b11, 1'b1, "gate clr");
		overtemp_raw <= 1'b1;
		wt(6);
		hw(2'b00, 1'b0, "hot");
		rc(3'h7, 12'h001, "hot flag");
		overtemp_raw <= 1'b0;
		wt(6);
		hw(2'b11, 1'b1, "cool");
		rc(3'h7, 12'h000, "hot clr");
		undervolt_raw <= 1'b1;
		wt(6);
		hw(2'b00, 1'b0, "uv");
		undervolt_raw <= 1'b0;
		wt(6);
		hw(2'b11, 1'b1, "uv end");
		rc(3'h7, 12'h020, "uv flag");
		low_power_pin_n <= 1'b0;
		wt(6);
		chk({gate_reg_en, 9'h0, bridge_en}, 12'h000, "sleep");
		wr(3'h7, 12'h000);
		rc(3'h7, 12'h020, "uv kept");
		wr(A_BLANK, 12'h155);
		chk(cfg[3], 12'h155, "sleep wr");
		reset_pin <= 1'b1;
		wt(10);
		chk(cfg[3], 12'h155, "rst in sleep");
		low_power_pin_n <= 1'b1;
		wt(6);
		chk(cfg[3], BLANK_RST, "rst on wake");
		wr(A_BLANK, 12'h0aa);
		stp();
		chk(cfg[3], BLANK_RST, "wr in rst");
		chk(12'(adv_cnt), 12'h002, "step in rst");
		hw(2'b00, 1'b1, "rst drive");
		reset_pin <= 1'b0;
		wt(6);
		rc(3'h7, 12'h000, "status rst");
		results();
	end
endmodule

// >>> bench/stp_host.sv
// host model: drives serial frames into the register port
`timescale 1ns/1ps
module stp_host (
	input  wire logic mclk,           // core clock
	output logic      frame_select,   // select, high in frame
	output logic      serial_clk,     // link clock, still outside frames
	output logic      serial_in_pin,  // data to device
	input  wire logic serial_out_pin  // data from device
);
	initial
	begin
		frame_select = 1'b0;
		serial_clk = 1'b0;
		serial_in_pin = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic xfer(input logic [15:0] w, input int nb, input int gap,
		output logic [11:0] r);
		r = '0;
		@(posedge mclk);
		frame_select <= 1'b1;
		for (int i = 0; i < nb; i++)
		begin
			serial_in_pin <= w[15-i];
			if (i == 8)
				wt(gap);
			wt(3);
			@(negedge mclk);
			if (i >= 4)
				r[15-i] = serial_out_pin;
			@(posedge mclk);
			serial_clk <= 1'b1;
			wt(4);
			serial_clk <= 1'b0;
		end
		wt(4);
		frame_select <= 1'b0;
		// released line: show inverse so a stale bit cannot look valid
		serial_in_pin <= ~w[16-nb];
		wt(8);
	endtask
endmodule

// >>> design/stp_core.sv
// stepper control core: fault supervision, sleep/reset, serial registers
`timescale 1ns/1ps
module stp_core import stp_pkg::*; (
	input  wire logic        mclk,            // core clock, 50 MHz
	input  wire logic        rst,             // supply-monitor reset, async high
	input  wire logic        reset_pin,       // reset pin, high active
	input  wire logic        low_power_pin_n, // sleep pin, low active
	input  wire logic        frame_select,    // serial chip select, high active
	input  wire logic        serial_clk,      // serial clock from host
	input  wire logic        serial_in_pin,   // serial data in
	input  wire logic        step_pin,        // step input
	input  wire logic        dir_pin,         // direction input
	input  wire logic [1:0]  ocp_raw,         // fet drop above threshold, per bridge
	input  wire logic [1:0]  gate_fault_raw,  // gate drive overcurrent, per bridge
	input  wire logic        overtemp_raw,    // die too hot
	input  wire logic        undervolt_raw,   // motor supply low
	output logic             serial_out_pin,  // serial data out
	output logic             fault_pin_low_o, // fault pin drive level
	output logic             fault_pin_low_oe_n, // fault pin enable, low drives
	output logic [1:0]       bridge_en,       // bridge enables, b is bit 1
	output logic             gate_reg_en,     // gate regulator and charge pump on
	output logic             step_advance,    // indexer advance pulse
	output logic             step_heading,    // effective direction
	output logic [11:0]      control_config,  // control word
	output logic [11:0]      current_sample_config, // torque and sample window
	output logic [11:0]      off_time_config, // off time and bypass
	output logic [11:0]      blanking_config, // blanking and adaptive
	output logic [11:0]      decay_config,    // decay time and select
	output logic [11:0]      drive_config     // threshold and filter time
);
	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	logic [12:0] pin_s;
	logic        sclk_s;
	logic        cs_s;
	logic        sdi_s;
	logic        step_s;
	logic        dir_s;
	logic        awake_s;
	logic        rstpin_s;
	logic        ots_c;
	logic        uv_c;
	logic [1:0]  pdf_s;
	logic [1:0]  ocp_s;

	stp_sync #(.W(13)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({serial_clk, frame_select, serial_in_pin, step_pin, dir_pin,
			low_power_pin_n, reset_pin, overtemp_raw, undervolt_raw,
			gate_fault_raw, ocp_raw}),
		.q    (pin_s)
	);
	assign {sclk_s, cs_s, sdi_s, step_s, dir_s, awake_s, rstpin_s, ots_c, uv_c,
		pdf_s, ocp_s} = pin_s;

	// ----------------------------------------------------------------
	// overcurrent filters
	// ----------------------------------------------------------------
	logic [FILT_W-1:0] ocp_limit;
	logic [1:0]        ocp_hit;
	stp_st_t           state_r;
	stp_st_t           state_nxt;

	always_comb
	begin
		case (state_r.drive[B_FILT_LO +: 2])
			2'h0:    ocp_limit = OCP_C0;
			2'h1:    ocp_limit = OCP_C1;
			2'h2:    ocp_limit = OCP_C2;
			default: ocp_limit = OCP_C3;
		endcase
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_ocp
		stp_filt_if fi ();
		assign fi.raw    = ocp_s[g];
		assign fi.limit  = ocp_limit;
		assign ocp_hit[g] = fi.hit;
		stp_filt u_filt (
			.mclk (mclk),
			.rst  (rst),
			.f    (fi)
		);
	end

	// ----------------------------------------------------------------
	// shared terms
	// ----------------------------------------------------------------
	logic        sleep;
	logic        soft_rst;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_fall;
	logic        wr_now;
	logic [2:0]  wr_addr;
	logic [11:0] wr_data;
	logic [15:0] sh_in;
	logic        fault_act;
	logic        bypass;
	logic        lock_a;
	logic        lock_b;
	logic        run_ok;
	logic [STAT_W-1:0] st_set;
	logic [STAT_W-1:0] st_clr;

	assign sleep = !awake_s;
	assign soft_rst  = rstpin_s && !sleep;
	assign sclk_rise = cs_s && sclk_s && !state_r.sclk_d;
	assign sclk_fall = cs_s && !sclk_s && state_r.sclk_d;
	assign cs_fall   = state_r.cs_d && !cs_s;
	// full frame only; first bit low writes
	assign wr_now    = cs_fall && (state_r.cnt == CNT_FULL) && !state_r.sh[15];
	assign wr_addr   = state_r.sh[14:12];
	assign wr_data   = state_r.sh[11:0];
	assign sh_in     = {state_r.sh[14:0], sdi_s};
	assign bypass    = state_r.off[B_BYPASS];
	assign lock_a    = state_r.stat[S_OCP_A] || state_r.stat[S_PDF_A];
	assign lock_b    = state_r.stat[S_OCP_B] || state_r.stat[S_PDF_B];
	assign fault_act = lock_a || lock_b || ots_c || uv_c;
	assign run_ok    = state_r.ctrl[B_MOTOR_ON] && !sleep && !ots_c && !uv_c;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	function automatic logic [11:0] rd_mux(input stp_st_t s, input logic [2:0] a);
		logic [11:0] v;
		v = 12'h000;
		if (a == A_CTRL)
			v = s.ctrl & CTRL_WMSK;
		else if (a == A_TORQUE)
			v = s.torque & TORQ_RMSK;
		else if (a == A_OFF)
			v = s.off;
		else if (a == A_BLANK)
			v = s.blank;
		else if (a == A_DECAY)
			v = s.decay;
		else if (a == A_DRIVE)
			v = s.drive;
		else if (a == A_STATUS)
			v = {{(12 - STAT_W){1'b0}}, s.stat};
		return v;
	endfunction

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	always_comb
	begin
		st_set = '0;
		st_set[S_OCP_A] = ocp_hit[0];
		st_set[S_OCP_B] = ocp_hit[1];
		st_set[S_PDF_A] = pdf_s[0];
		st_set[S_PDF_B] = pdf_s[1];
		st_set[S_UV]    = uv_c;
		st_set[S_OTS]   = ots_c;
		st_clr = '0;
		if (wr_now && wr_addr == A_STATUS)
			st_clr = ~wr_data[STAT_W-1:0];
		if (sleep)
			st_clr[S_UV] = 1'b0;
		st_clr[S_OTS] = 1'b1;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt        = state_r;
		state_nxt.sclk_d = sclk_s;
		state_nxt.cs_d   = cs_s;
		state_nxt.step_d = step_s;
		state_nxt.adv    = 1'b0;
		// set beats clear
		state_nxt.stat   = st_set | (state_r.stat & ~st_clr);

		if (cs_s && !state_r.cs_d)
		begin
			state_nxt.cnt = '0;
			state_nxt.rdm = 1'b0;
		end
		else if (sclk_rise && state_r.cnt != CNT_FULL)
		begin
			state_nxt.sh  = sh_in;
			state_nxt.cnt = state_r.cnt + 5'h01;
			if (state_r.cnt == CNT_HEAD && sh_in[HEAD_BITS-1])
			begin
				state_nxt.rdm = 1'b1;
				state_nxt.rd  = rd_mux(state_r, sh_in[2:0]);
			end
		end

		if (sclk_fall && state_r.rdm)
		begin
			state_nxt.sdo = state_r.rd[11];
			state_nxt.rd  = {state_r.rd[10:0], 1'b0};
		end
		if (!cs_s)
			state_nxt.sdo = 1'b0;

		if (wr_now)
		begin
			if (wr_addr == A_CTRL)
				state_nxt.ctrl = wr_data & CTRL_WMSK;
			else if (wr_addr == A_TORQUE)
				state_nxt.torque = wr_data & TORQ_WMSK;
			else if (wr_addr == A_OFF)
				state_nxt.off = wr_data & W9_MSK;
			else if (wr_addr == A_BLANK)
				state_nxt.blank = wr_data & W9_MSK;
			else if (wr_addr == A_DECAY)
				state_nxt.decay = wr_data & DECAY_MSK;
			else if (wr_addr == A_DRIVE)
				state_nxt.drive = wr_data;
		end

		// steps ignored on fault; self-clearing step
		state_nxt.adv = !fault_act && ((step_s && !state_r.step_d) ||
			(wr_now && wr_addr == A_CTRL && wr_data[B_SINGLE]));
		state_nxt.heading = dir_s ^ state_r.ctrl[B_REVERSE];

		state_nxt.br[0] = run_ok && !(bypass ? lock_a : (lock_a || lock_b));
		state_nxt.br[1] = run_ok && !(bypass ? lock_b : (lock_a || lock_b));
		state_nxt.flt   = lock_a || lock_b || ots_c || uv_c;
		state_nxt.awake = !sleep;

		if (soft_rst)
		begin
			state_nxt        = ST_RST;
			state_nxt.sclk_d = sclk_s;
			state_nxt.cs_d   = cs_s;
			state_nxt.step_d = step_s;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_r <= ST_RST;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign serial_out_pin        = state_r.sdo;
	assign fault_pin_low_o       = 1'b0;
	assign fault_pin_low_oe_n    = !state_r.flt;
	assign bridge_en             = state_r.br;
	assign gate_reg_en           = state_r.awake;
	assign step_advance          = state_r.adv;
	assign step_heading          = state_r.heading;
	assign control_config        = state_r.ctrl;
	assign current_sample_config = state_r.torque;
	assign off_time_config       = state_r.off;
	assign blanking_config       = state_r.blank;
	assign decay_config          = state_r.decay;
	assign drive_config          = state_r.drive;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_ocp_latch;
		ocp_hit[0] && !soft_rst |=> state_r.stat[S_OCP_A] ##1 !fault_pin_low_oe_n;
	endproperty
	a_ocp_latch: assert property (p_ocp_latch) else $error("overcurrent not latched");

	property p_idx_both;
		!bypass && lock_a && !soft_rst |=> bridge_en == 2'b00;
	endproperty
	a_idx_both: assert property (p_idx_both) else $error("bridge left on");

	property p_direct_one;
		bypass && lock_a && !lock_b && run_ok && !soft_rst |=> !bridge_en[0] && bridge_en[1];
	endproperty
	a_direct_one: assert property (p_direct_one) else $error("wrong bridge off");

	property p_ocp_hold;
		state_r.stat[S_OCP_A] && !soft_rst && !(wr_now && wr_addr == A_STATUS)
			|=> state_r.stat[S_OCP_A];
	endproperty
	a_ocp_hold: assert property (p_ocp_hold) else $error("overcurrent flag lost");

	property p_ots;
		ots_c && !soft_rst |=> bridge_en == 2'b00 && state_r.stat[S_OTS];
	endproperty
	a_ots: assert property (p_ots) else $error("overtemp not handled");

	property p_uv_sleep;
		state_r.stat[S_UV] && sleep && !soft_rst |=> state_r.stat[S_UV];
	endproperty
	a_uv_sleep: assert property (p_uv_sleep) else $error("undervoltage cleared");

	property p_step_block;
		fault_act && !soft_rst |=> !step_advance;
	endproperty
	a_step_block: assert property (p_step_block) else $error("step during fault");

	property p_soft_rst;
		soft_rst |=> bridge_en == 2'b00 && control_config == CTRL_RST && !step_advance;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("reset not applied");

	property p_sleep;
		sleep && !soft_rst |=> !gate_reg_en && bridge_en == 2'b00;
	endproperty
	a_sleep: assert property (p_sleep) else $error("drive on in sleep");

	property p_write;
		wr_now && wr_addr == A_OFF && !soft_rst |=> off_time_config == (wr_data & W9_MSK);
	endproperty
	a_write: assert property (p_write) else $error("write lost");

	c_write: cover property (wr_now);
	c_read: cover property (sclk_rise && state_r.cnt == CNT_HEAD && sh_in[HEAD_BITS-1]);
	c_ocp: cover property (ocp_hit[1] ##1 state_r.stat[S_OCP_B]);
	c_step: cover property (step_advance);
endmodule

// >>> design/stp_filt.sv
// overcurrent filter: raw must stay high longer than the limit
`timescale 1ns/1ps
module stp_filt import stp_pkg::*; (
	input  wire logic mclk, // core clock
	input  wire logic rst,  // async reset, high
	stp_filt_if.filt  f     // raw in, limit in, hit out
);
	logic [FILT_W-1:0] cnt_r;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			f.hit <= 1'b0;
		end
		else if (!f.raw)
		begin
			cnt_r <= '0;
			f.hit <= 1'b0;
		end
		else
		begin
			if (cnt_r < f.limit)
				cnt_r <= cnt_r + FILT_W'(1);
			f.hit <= (cnt_r >= f.limit);
		end
	end
endmodule

// >>> design/stp_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module stp_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk, // core clock
	input  wire logic         rst,  // async reset, high
	input  wire logic [W-1:0] d,    // asynchronous inputs
	output logic      [W-1:0] q     // synchronised outputs
);
	logic [W-1:0] meta_r;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// >>> pkg/stp_filt_if.sv
// overcurrent filter hookup between core and one filter channel
`timescale 1ns/1ps
interface stp_filt_if;
	logic                      raw;
	logic [stp_pkg::FILT_W-1:0] limit;
	logic                      hit;
	modport core (output raw, output limit, input hit);
	modport filt (input raw, input limit, output hit);
endinterface

// >>> pkg/stp_pkg.sv
// stepper control core: shared constants, register layout and state type
// What this block does
// - overcurrent only after drop exceeds filter time
// - direct mode stops one bridge, indexer both
// - overcurrent sets flag, fault low, held latched
// - gate-driver fault latches flag; stops both bridges, in direct mode only its own
// - overtemperature stops all, self-clears, releases fault
// - undervoltage stops all; flag stays until cleared
// - step edges ignored during any fault
// - reset restores defaults, stops drive, ignores inputs
// - sleep stops drive; registers stay accessible
// - reset ignored in sleep; undervoltage flag kept
// - frame is rw bit, 3 address, 12 data
// - select high whole frame; low completes it
// - first bit 0 writes addressed register
// - first bit 1 reads; input data ignored
// - control enable, direction invert, self-clearing step
// - step-size field in control bits 6-3
// - stall select bit 7, dead time 11-10
// - torque 7-0, sample window 10-8, bit10 reads 0
// - off time 7-0, indexer bypass bit 8
// - blanking 7-0, adaptive blanking bit 8
// - decay time 7-0, decay select 10-8
// - status bits: temp, overcurrent, gate, undervoltage
// - overcurrent threshold code selects 250-1000 mV
package stp_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS     = 20;
	localparam int OCP_T0_NS  = 1000;
	localparam int OCP_T1_NS  = 2000;
	localparam int OCP_T2_NS  = 4000;
	localparam int OCP_T3_NS  = 8000;
	localparam int FILT_W     = 9;
	localparam logic [FILT_W-1:0] OCP_C0 = FILT_W'((OCP_T0_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OCP_C1 = FILT_W'((OCP_T1_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OCP_C2 = FILT_W'((OCP_T2_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [FILT_W-1:0] OCP_C3 = FILT_W'((OCP_T3_NS + CLK_NS - 1) / CLK_NS);
	// ----------------------------------------------------------------
	// serial frame
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int HEAD_BITS  = 4;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_HEAD = 5'h03;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [2:0] A_CTRL   = 3'h0;
	localparam logic [2:0] A_TORQUE = 3'h1;
	localparam logic [2:0] A_OFF    = 3'h2;
	localparam logic [2:0] A_BLANK  = 3'h3;
	localparam logic [2:0] A_DECAY  = 3'h4;
	localparam logic [2:0] A_DRIVE  = 3'h6;
	localparam logic [2:0] A_STATUS = 3'h7;
	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_RST   = 12'hc10;
	localparam logic [11:0] TORQUE_RST = 12'h1ff;
	localparam logic [11:0] OFF_RST    = 12'h030;
	localparam logic [11:0] BLANK_RST  = 12'h080;
	localparam logic [11:0] DECAY_RST  = 12'h110;
	localparam logic [11:0] DRIVE_RST  = 12'ha59;
	localparam logic [11:0] CTRL_WMSK  = 12'hffb;
	localparam logic [11:0] TORQ_WMSK  = 12'h7ff;
	localparam logic [11:0] TORQ_RMSK  = 12'h3ff;
	localparam logic [11:0] W9_MSK     = 12'h1ff;
	localparam logic [11:0] DECAY_MSK  = 12'h7ff;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_MOTOR_ON  = 0;
	localparam int B_REVERSE   = 1;
	localparam int B_SINGLE    = 2;
	localparam int B_BYPASS    = 8;
	localparam int B_THR_LO    = 0;
	localparam int B_FILT_LO   = 2;
	localparam int S_OTS       = 0;
	localparam int S_OCP_A     = 1;
	localparam int S_OCP_B     = 2;
	localparam int S_PDF_A     = 3;
	localparam int S_PDF_B     = 4;
	localparam int S_UV        = 5;
	localparam int STAT_W      = 6;
	// ----------------------------------------------------------------
	// core state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0]       ctrl;
		logic [11:0]       torque;
		logic [11:0]       off;
		logic [11:0]       blank;
		logic [11:0]       decay;
		logic [11:0]       drive;
		logic [STAT_W-1:0] stat;
		logic [15:0]       sh;
		logic [4:0]        cnt;
		logic              rdm;
		logic [11:0]       rd;
		logic              sdo;
		logic              adv;
		logic              heading;
		logic [1:0]        br;
		logic              flt;
		logic              awake;
		logic              sclk_d;
		logic              cs_d;
		logic              step_d;
	} stp_st_t;
	localparam stp_st_t ST_RST = '{ctrl: CTRL_RST, torque: TORQUE_RST, off: OFF_RST,
		blank: BLANK_RST, decay: DECAY_RST, drive: DRIVE_RST, default: '0};
endpackage
